//--- rcs_defs.svh
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// Register byte offsets
`define RCS_OFS_CTRL      4'h0
`define RCS_OFS_STAT      4'h4
`define RCS_OFS_FREQ      4'h8
`define RCS_OFS_TRIM      4'hC

// Control register fields
`define RCS_CTRL_SLEEP    0
`define RCS_CTRL_COMB     1
`define RCS_CTRL_REQFN    2
`define RCS_CTRL_GPIO     3
`define RCS_CTRL_LPCINT   4
`define RCS_CTRL_RST      8'h04

// Frequency in 80 Hz units: default 20 MHz, accepted span 12 to 52 MHz
`define RCS_FREQ_DEF      20'h3D090
`define RCS_FREQ_MIN      20'h249F0
`define RCS_FREQ_MAX      20'h9EB10

// Trim in 2 ppm steps, limited to +/-50 ppm
`define RCS_TRIM_MAX      8'h19
`define RCS_TRIM_RST      8'h00

// Detection window in low-power clock periods, acceptance in reference/16 counts
`define RCS_DET_PERIODS   32
`define RCS_DET_TOL       12'h003
`define RCS_DET_TMO_US    2000
`define RCS_CORE_MHZ      40

// AXI responses
`define RCS_RESP_OK       2'h0
`define RCS_RESP_DEC      2'h3

`endif

//--- rcs_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: reference prescaler output, free-running low-power clock, system request
module rcs_osc_model (
    // System request level from the bench
    input  wire logic req_i,
    // Pins toward the block
    output var logic  lpc_o,
    output var logic  ref_div_o,
    output logic      req_o
);
    realtime ref_half = 60.0;

    // Low-power clock scaled to 8 us so a detection window stays short
    initial lpc_o = 1'b0;
    always #4000 lpc_o = ~lpc_o;

    // Reference divided by 16, exact period so detection sees no drift
    initial ref_div_o = 1'b0;
    always #(ref_half) ref_div_o = ~ref_div_o;

    // Never floats: anything but a clean one is driven as zero
    assign req_o = (req_i === 1'b1);
endmodule
`default_nettype wire

//--- rcs_pkg.sv
`default_nettype none
package rcs_pkg;
    typedef enum {ST_NV, ST_DET, ST_RUN} rcs_state_e;
    typedef enum logic [1:0] {SRC_DEF, SRC_NV, SRC_AUTO} rcs_src_e;
    typedef logic [19:0] rcs_freq_t;
    // Standard reference frequencies in 80 Hz units, 12 up to 38.4 MHz
    localparam rcs_freq_t RCS_STD [17] = '{
        20'h249F0, 20'h27AC4, 20'h2BF20, 20'h2EE00, 20'h31704, 20'h33450,
        20'h36EE8, 20'h3A980, 20'h3B538, 20'h3C0F0, 20'h3C6CC, 20'h3D090,
        20'h493E0, 20'h4F588, 20'h668A0, 20'h7222C, 20'h75300};
endpackage
`default_nettype wire

//--- rcs_rate_meter.sv
`timescale 1ns/1ps
`default_nettype none
// Counts reference/16 edges across a fixed number of low-power clock periods
module rcs_rate_meter #(
    parameter int PERIODS = 32,
    parameter int TMO_CYC = 80000
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Control and edges
    input  wire logic        start_i,
    input  wire logic        lpc_rise_i,
    input  wire logic        ref_rise_i,
    // Result
    output logic             done_o,
    output logic             tmo_o,
    output logic [11:0]      count_o
);
    logic        run_q;
    logic        arm_q;
    logic [6:0]  per_q;
    logic [11:0] cnt_q;
    logic [17:0] tmo_q;
    // Arming edge starts period zero, so the last edge closes exactly PERIODS periods
    wire         last_per = arm_q && (per_q == 7'(PERIODS - 1));
    wire         tmo_hit  = (tmo_q == 18'(TMO_CYC));

    // Window opens on the first low-power edge so partial periods never count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q   <= 1'b0;
            arm_q   <= 1'b0;
            per_q   <= 7'h00;
            cnt_q   <= 12'h000;
            tmo_q   <= 18'h00000;
            done_o  <= 1'b0;
            tmo_o   <= 1'b0;
            count_o <= 12'h000;
        end else begin
            done_o <= 1'b0;
            tmo_o  <= 1'b0;
            if (start_i) begin
                run_q <= 1'b1;
                arm_q <= 1'b0;
                per_q <= 7'h00;
                cnt_q <= 12'h000;
                tmo_q <= 18'h00000;
            end else if (run_q) begin
                tmo_q <= tmo_q + 18'h00001;
                if (tmo_hit) begin
                    run_q <= 1'b0;
                    tmo_o <= 1'b1;
                end else if (lpc_rise_i && last_per) begin
                    run_q   <= 1'b0;
                    done_o  <= 1'b1;
                    count_o <= cnt_q;
                end else begin
                    if (lpc_rise_i) begin
                        arm_q <= 1'b1;
                        per_q <= arm_q ? per_q + 7'h01 : 7'h00;
                    end
                    if (ref_rise_i && arm_q && cnt_q != 12'hFFF) begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- rcs_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defs.svh"
// Contract
// - Request asserted while awake, dropped asleep
// - Request output is active high
// - Sleep uses low-power clock as timing
// - Combined request is OR of both
// - OR path works with core asleep
// - Request pin can serve as GPIO
// - Default reference is 20 MHz
// - Three ways: default, NVRAM, auto-detect
// - Parameters load from NVRAM at power-on
// - Auto-detect picks only standard frequencies
// - Accept 12 to 52 MHz, 80 Hz steps
// - Trim range limited to +/-50 ppm
// - Serial and audio timing use configured frequency
// - Detected frequency applied without intervention
// - Trim from host command or NVRAM
module rcs_top #(
    parameter int DET_PERIODS = `RCS_DET_PERIODS,
    parameter int DET_TMO_CYC = `RCS_DET_TMO_US * `RCS_CORE_MHZ
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_I,
    // AXI4-Lite write channels
    input  wire logic        AXI_AWVALID_I,
    output logic             AXI_AWREADY_O,
    input  wire logic [3:0]  AXI_AWADDR_I,
    input  wire logic        AXI_WVALID_I,
    output logic             AXI_WREADY_O,
    input  wire logic [31:0] AXI_WDATA_I,
    input  wire logic [3:0]  AXI_WSTRB_I,
    output logic             AXI_BVALID_O,
    input  wire logic        AXI_BREADY_I,
    output logic [1:0]       AXI_BRESP_O,
    // AXI4-Lite read channels
    input  wire logic        AXI_ARVALID_I,
    output logic             AXI_ARREADY_O,
    input  wire logic [3:0]  AXI_ARADDR_I,
    output logic             AXI_RVALID_O,
    input  wire logic        AXI_RREADY_I,
    output logic [31:0]      AXI_RDATA_O,
    output logic [1:0]       AXI_RRESP_O,
    // Pins: low-power clock, reference divided by 16, partner request
    input  wire logic        LPC_I,
    input  wire logic        REF_DIV_I,
    input  wire logic        REQ_IN_I,
    // Power-on parameter set from NVRAM loader
    input  wire logic        NV_DONE_I,
    input  wire logic        NV_FREQ_VLD_I,
    input  wire logic [19:0] NV_FREQ_I,
    input  wire logic        NV_TRIM_VLD_I,
    input  wire logic [7:0]  NV_TRIM_I,
    // Clock request and timing outputs
    output logic             REQ_PIN_O,
    output logic             CLK_REQ_O,
    output logic             SLEEP_TB_O,
    output logic             LPC_INT_O,
    output logic [19:0]      FREQ_O,
    output logic             FREQ_VLD_O,
    output logic [7:0]       TRIM_O
);
    rcs_pkg::rcs_state_e st_q;
    rcs_pkg::rcs_src_e   src_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  trim_q;
    logic [19:0] freq_q;
    logic        clk_req_q;
    logic [2:0]  lpc_s_q;
    logic [2:0]  ref_s_q;
    logic        m_start_q;
    logic        m_done;
    logic        m_tmo;
    logic [11:0] m_count;
    logic        aw_have_q;
    logic        w_have_q;
    logic [3:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // Control fields
    wire sleep_q  = ctrl_q[`RCS_CTRL_SLEEP];
    wire comb_en  = ctrl_q[`RCS_CTRL_COMB];
    wire req_fn   = ctrl_q[`RCS_CTRL_REQFN];
    wire gpio_val = ctrl_q[`RCS_CTRL_GPIO];

    // Pad-ring OR: no flop on the path so it holds with the clock stopped
    wire req_or   = REQ_IN_I | clk_req_q;
    wire req_path = comb_en ? req_or : clk_req_q;
    assign REQ_PIN_O = req_fn ? req_path : gpio_val;

    // Two-stage synchronisers, third stage only for edge detection
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lpc_s_q <= 3'h0;
            ref_s_q <= 3'h0;
        end else begin
            lpc_s_q <= {lpc_s_q[1:0], LPC_I};
            ref_s_q <= {ref_s_q[1:0], REF_DIV_I};
        end
    end
    wire lpc_rise = lpc_s_q[1] & ~lpc_s_q[2];
    wire ref_rise = ref_s_q[1] & ~ref_s_q[2];

    // Measures reference against the low-power clock
    rcs_rate_meter #(
        .PERIODS (DET_PERIODS),
        .TMO_CYC (DET_TMO_CYC)
    ) u_meter (
        .clk_i      (CORE_CLK_I),
        .rst_i      (RST_I),
        .start_i    (m_start_q),
        .lpc_rise_i (lpc_rise),
        .ref_rise_i (ref_rise),
        .done_o     (m_done),
        .tmo_o      (m_tmo),
        .count_o    (m_count)
    );

    // Nearest standard frequency within tolerance; bit 5 flags a hit
    function automatic logic [5:0] pick(input logic [11:0] c);
        logic [39:0] e;
        logic [11:0] d;
        logic [11:0] best;
        logic [5:0]  r;
        best = 12'hFFF;
        r    = 6'h00;
        for (int i = 0; i < 17; i++) begin
            e = (40'(rcs_pkg::RCS_STD[i]) * 40'(5 * DET_PERIODS) + 40'h0000004000) >> 15;
            d = (c >= e[11:0]) ? c - e[11:0] : e[11:0] - c;
            if (d <= `RCS_DET_TOL && d < best) begin
                best = d;
                r    = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction
    wire [5:0] hit    = pick(m_count);
    wire       nv_ok  = NV_FREQ_VLD_I && NV_FREQ_I >= `RCS_FREQ_MIN
                        && NV_FREQ_I <= `RCS_FREQ_MAX;

    // Trim limit to the +/-50 ppm span
    function automatic logic [7:0] clamp(input logic [7:0] t);
        if ($signed(t) > $signed(`RCS_TRIM_MAX)) begin
            return `RCS_TRIM_MAX;
        end else if ($signed(t) < -$signed(`RCS_TRIM_MAX)) begin
            return 8'(-$signed(`RCS_TRIM_MAX));
        end
        return t;
    endfunction

    // Power-on selection: NVRAM first, then detection, else default
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q      <= rcs_pkg::ST_NV;
            src_q     <= rcs_pkg::SRC_DEF;
            freq_q    <= `RCS_FREQ_DEF;
            m_start_q <= 1'b0;
        end else begin
            m_start_q <= 1'b0;
            case (st_q)
                rcs_pkg::ST_NV: begin
                    if (NV_DONE_I) begin
                        if (nv_ok) begin
                            freq_q <= NV_FREQ_I;
                            src_q  <= rcs_pkg::SRC_NV;
                            st_q   <= rcs_pkg::ST_RUN;
                        end else begin
                            m_start_q <= 1'b1;
                            st_q      <= rcs_pkg::ST_DET;
                        end
                    end
                end
                rcs_pkg::ST_DET: begin
                    if (m_done && hit[5]) begin
                        freq_q <= rcs_pkg::RCS_STD[hit[4:0]];
                        src_q  <= rcs_pkg::SRC_AUTO;
                        st_q   <= rcs_pkg::ST_RUN;
                    end else if (m_done || m_tmo) begin
                        st_q <= rcs_pkg::ST_RUN;
                    end
                end
                rcs_pkg::ST_RUN: begin
                    st_q <= rcs_pkg::ST_RUN;
                end
                default: begin
                    st_q <= rcs_pkg::ST_NV;
                end
            endcase
        end
    end

    // Decode of the held write
    wire wr_go   = aw_have_q && w_have_q && !AXI_BVALID_O;
    wire wr_ctrl = wr_go && aw_addr_q == `RCS_OFS_CTRL && w_strb_q[0];
    wire wr_trim = wr_go && aw_addr_q == `RCS_OFS_TRIM && w_strb_q[0];
    wire wr_bad  = aw_addr_q[1:0] != 2'h0;
    wire nv_trim = st_q == rcs_pkg::ST_NV && NV_DONE_I && NV_TRIM_VLD_I;

    // Control and trim registers; a host write after power-on overrides NVRAM
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_q <= `RCS_CTRL_RST;
            trim_q <= `RCS_TRIM_RST;
        end else begin
            if (wr_ctrl && !wr_bad) begin
                ctrl_q <= {3'h0, w_data_q[4:0]};
            end
            if (wr_trim && !wr_bad) begin
                trim_q <= clamp(w_data_q[7:0]);
            end else if (nv_trim) begin
                trim_q <= clamp(NV_TRIM_I);
            end
        end
    end

    // Request and timing outputs follow awake state and registers one cycle later
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_req_q  <= 1'b1;
            CLK_REQ_O  <= 1'b1;
            SLEEP_TB_O <= 1'b0;
            LPC_INT_O  <= 1'b0;
            FREQ_O     <= `RCS_FREQ_DEF;
            FREQ_VLD_O <= 1'b0;
            TRIM_O     <= `RCS_TRIM_RST;
        end else begin
            clk_req_q  <= !sleep_q;
            CLK_REQ_O  <= !sleep_q;
            SLEEP_TB_O <= sleep_q;
            LPC_INT_O  <= ctrl_q[`RCS_CTRL_LPCINT];
            FREQ_O     <= freq_q;
            FREQ_VLD_O <= st_q == rcs_pkg::ST_RUN;
            TRIM_O     <= trim_q;
        end
    end

    // Write channels: address and data taken in either order, one at a time
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 4'h0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            AXI_AWREADY_O <= 1'b1;
            AXI_WREADY_O  <= 1'b1;
            AXI_BVALID_O  <= 1'b0;
            AXI_BRESP_O   <= `RCS_RESP_OK;
        end else begin
            if (AXI_AWVALID_I && AXI_AWREADY_O) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= AXI_AWADDR_I;
                AXI_AWREADY_O <= 1'b0;
            end
            if (AXI_WVALID_I && AXI_WREADY_O) begin
                w_have_q     <= 1'b1;
                w_data_q     <= AXI_WDATA_I;
                w_strb_q     <= AXI_WSTRB_I;
                AXI_WREADY_O <= 1'b0;
            end
            if (wr_go) begin
                AXI_BVALID_O <= 1'b1;
                AXI_BRESP_O  <= (wr_bad || aw_addr_q[3:2] == 2'h1 || aw_addr_q[3:2] == 2'h2)
                                ? `RCS_RESP_DEC : `RCS_RESP_OK;
            end
            if (AXI_BVALID_O && AXI_BREADY_I) begin
                AXI_BVALID_O  <= 1'b0;
                aw_have_q     <= 1'b0;
                w_have_q      <= 1'b0;
                AXI_AWREADY_O <= 1'b1;
                AXI_WREADY_O  <= 1'b1;
            end
        end
    end

    // Read decode: status shows source, completion and awake state
    wire [31:0] rd_mux =
        (AXI_ARADDR_I == `RCS_OFS_CTRL) ? {24'h000000, ctrl_q} :
        (AXI_ARADDR_I == `RCS_OFS_STAT) ? {28'h0000000, !sleep_q,
                                           st_q == rcs_pkg::ST_RUN, src_q} :
        (AXI_ARADDR_I == `RCS_OFS_FREQ) ? {12'h000, freq_q} :
        (AXI_ARADDR_I == `RCS_OFS_TRIM) ? {24'h000000, trim_q} : 32'h00000000;
    wire rd_ok = AXI_ARADDR_I[1:0] == 2'h0;

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O  <= 1'b0;
            AXI_RDATA_O   <= 32'h00000000;
            AXI_RRESP_O   <= `RCS_RESP_OK;
        end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O  <= 1'b1;
            AXI_RDATA_O   <= rd_ok ? rd_mux : 32'h00000000;
            AXI_RRESP_O   <= rd_ok ? `RCS_RESP_OK : `RCS_RESP_DEC;
        end else if (AXI_RVALID_O && AXI_RREADY_I) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O  <= 1'b0;
        end
    end

    // Checks on request, selection and range behaviour
    a_req_sleep: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $rose(sleep_q) |=> !CLK_REQ_O ##1 (!CLK_REQ_O || !sleep_q))
        else $error("request still high after sleep");
    a_req_awake: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (!sleep_q)[*2] |-> CLK_REQ_O && clk_req_q)
        else $error("request low while awake");
    a_sleep_tb: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        sleep_q |=> SLEEP_TB_O)
        else $error("low-power timing not selected in sleep");
    a_or_pin: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        req_fn && comb_en |-> REQ_PIN_O == (REQ_IN_I | clk_req_q))
        else $error("combined request is not an OR");
    a_gpio_use: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !req_fn |-> REQ_PIN_O == gpio_val)
        else $error("pin not released to general use");
    a_nv_first: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        st_q == rcs_pkg::ST_NV && NV_DONE_I && nv_ok |=> src_q == rcs_pkg::SRC_NV
        ##1 FREQ_VLD_O && FREQ_O == $past(NV_FREQ_I, 2))
        else $error("NVRAM frequency not applied first");
    a_auto_pick: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        st_q == rcs_pkg::ST_DET && m_done && hit[5]
        |=> src_q == rcs_pkg::SRC_AUTO && freq_q == rcs_pkg::RCS_STD[$past(hit[4:0])])
        else $error("detected frequency not applied");
    a_def_freq: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        src_q == rcs_pkg::SRC_DEF |-> freq_q == `RCS_FREQ_DEF)
        else $error("default frequency wrong");
    a_trim_span: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $signed(trim_q) <= $signed(`RCS_TRIM_MAX) && $signed(trim_q) >= -$signed(`RCS_TRIM_MAX))
        else $error("trim outside span");
    a_freq_span: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        FREQ_VLD_O |-> FREQ_O >= `RCS_FREQ_MIN && FREQ_O <= `RCS_FREQ_MAX)
        else $error("frequency outside accepted span");
endmodule
`default_nettype wire

//--- reference_clock_request_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defs.svh"
module reference_clock_request_select_tb_top;
    // Bench drive and observe
    logic              clk = 1'b0;
    logic              run = 1'b1;
    logic              rst = 1'b1;
    logic              awv, wv, br, arv, rr, nvd, nfv, ntv, req;
    logic [3:0]        awa, ws, ara;
    logic [31:0]       wd;
    logic [19:0]       nf;
    logic [7:0]        nt;
    wire logic         awr, wr, bv, arr, rv, lpc, refd, reqp, pin, creq, stb, lint, fvld;
    wire logic [1:0]   bresp, rresp;
    wire logic [31:0]  rdata;
    wire logic [19:0]  freq;
    wire logic [7:0]   trim;
    int                err_count = 0;
    int                total_checks = 0;
    int                seed = 97;

    // Clock can be halted to show the request path needs none
    always #12.5 clk = run ? ~clk : clk;

    // Timeout cut to 20000 cycles, still above one detection window
    rcs_top #(.DET_PERIODS(32), .DET_TMO_CYC(20000)) dut (
        .CORE_CLK_I(clk), .RST_I(rst),
        .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa),
        .AXI_WVALID_I(wv), .AXI_WREADY_O(wr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws),
        .AXI_BVALID_O(bv), .AXI_BREADY_I(br), .AXI_BRESP_O(bresp),
        .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara),
        .AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
        .LPC_I(lpc), .REF_DIV_I(refd), .REQ_IN_I(reqp),
        .NV_DONE_I(nvd), .NV_FREQ_VLD_I(nfv), .NV_FREQ_I(nf), .NV_TRIM_VLD_I(ntv),
        .NV_TRIM_I(nt), .REQ_PIN_O(pin), .CLK_REQ_O(creq), .SLEEP_TB_O(stb),
        .LPC_INT_O(lint), .FREQ_O(freq), .FREQ_VLD_O(fvld), .TRIM_O(trim)
    );
    rcs_osc_model u_osc (.req_i(req), .lpc_o(lpc), .ref_div_o(refd), .req_o(reqp));

    // Expectation helpers
    function automatic real half_for(int f);
        int c;
        c = (f * 160 + 16384) / 32768;
        return 128000.0 / c;
    endfunction
    function automatic logic pin_exp(logic [7:0] c, logic r);
        return c[2] ? (c[1] ? (r | !c[0]) : !c[0]) : c[3];
    endfunction
    function automatic logic [7:0] clamp(logic [7:0] v);
        return ($signed(v) > 25) ? 8'h19 : (($signed(v) < -25) ? 8'hE7 : v);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Each channel released only at the edge that takes it
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        @(posedge clk);
        {awv, wv, br, awa, wd, ws} <= {3'b111, a, d, s};
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(br && bv));
        chk("bresp", bresp, er);
        br <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {arv, rr, ara} <= {2'b11, a};
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!(rr && rv));
        d = rdata;
        r = rresp;
        rr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(nm, d, e);
        chk("rresp", r, 2'h0);
    endtask

    // Power-on pass: reset, hand over the NVRAM set, wait for selection
    task automatic sel(input string nm, input logic fv, input logic [19:0] f,
                       input logic [7:0] t, input real h, input logic [19:0] ef,
                       input logic [7:0] es);
        u_osc.ref_half = h;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        chk("rst_freq", freq, `RCS_FREQ_DEF);
        chk("rst_req", {creq, pin, stb, fvld}, 4'hC);
        rst <= 1'b0;
        @(posedge clk);
        {nvd, nfv, nf, ntv, nt} <= {1'b1, fv, f, 1'b1, t};
        @(posedge clk);
        nvd <= 1'b0;
        // Ends when fvld rises; the watchdog covers a hang
        while (fvld !== 1'b1) begin
            @(posedge clk);
        end
        chk("freq", freq, ef);
        chk("trim_nv", trim, t);
        rd_chk("stat", 4'h4, {24'h0, es});
        $display("test %s done", nm);
    endtask

    // About two and a half times the three detection windows; a hang counts as a mismatch
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end

    initial begin : main
        logic [19:0] f;
        logic [7:0]  t;
        logic [7:0]  c;
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  ctl [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h00, 8'h08, 8'h0C, 8'h14};
        logic [7:0]  tin [6] = '{8'h7F, 8'h80, 8'h19, 8'hE7, 8'h1A, 8'h00};
        {awv, wv, br, arv, rr, nvd, nfv, ntv, req} = '0;
        {awa, ws, ara, wd, nf, nt} = '0;
        f = 20'h249F0 + 20'($unsigned($random(seed)) % 500001);
        t = 8'($unsigned($random(seed)) % 51 - 25);
        sel("nvram", 1'b1, f, t, 60.0, f, 8'h0D);
        sel("nv_max", 1'b1, 20'h9EB10, 8'h00, 60.0, 20'h9EB10, 8'h0D);
        sel("auto_lo", 1'b1, 20'h9EB11, 8'h00, half_for(rcs_pkg::RCS_STD[0]),
            rcs_pkg::RCS_STD[0], 8'h0E);
        sel("auto_hi", 1'b0, 20'h0, 8'h00, half_for(rcs_pkg::RCS_STD[16]),
            rcs_pkg::RCS_STD[16], 8'h0E);
        sel("default", 1'b0, 20'h0, 8'h00, half_for(370000), `RCS_FREQ_DEF, 8'h0C);
        // Every request mode against both system request levels
        foreach (ctl[i]) begin
            c = ctl[i];
            axi_wr(4'h0, {24'h0, c}, 4'hF, 2'h0);
            rd_chk("ctrl", 4'h0, {24'h0, c});
            chk("clk_req", creq, !c[0]);
            chk("sleep_lpc", {stb, lint}, {c[0], c[4]});
            rd_chk("stat_awake", 4'h4, {28'h0, !c[0], 3'b100});
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                req <= k[0];
                #1 chk("pin", pin, pin_exp(c, k[0]));
            end
        end
        $display("test ctrl done");
        // Halted clock, core asleep: the OR must still follow
        axi_wr(4'h0, 32'h07, 4'hF, 2'h0);
        repeat (2) @(posedge clk);
        run = 1'b0;
        for (int k = 0; k < 4; k++) begin
            #100 req = k[0];
            #1 chk("pin_noclk", pin, k[0]);
        end
        run = 1'b1;
        $display("test noclk done");
        // Trim clamps at both ends, corners then random values
        for (int i = 0; i < 12; i++) begin
            t = (i < 6) ? tin[i] : 8'($random(seed));
            axi_wr(4'hC, {24'h0, t}, 4'hF, 2'h0);
            axi_rd(4'hC, d, r);
            chk("trim_rd", d[7:0], clamp(t));
            chk("trim_o", trim, clamp(t));
        end
        $display("test trim done");
        // Refused accesses and a write without byte 0 strobe leave state alone
        axi_wr(4'h8, 32'h1234, 4'hF, 2'h3);
        rd_chk("freq_rd", 4'h8, {12'h0, `RCS_FREQ_DEF});
        axi_wr(4'h4, 32'h0, 4'hF, 2'h3);
        axi_wr(4'h1, 32'h05, 4'hF, 2'h3);
        axi_wr(4'h0, 32'h05, 4'hE, 2'h0);
        rd_chk("ctrl_keep", 4'h0, 32'h07);
        axi_rd(4'h2, d, r);
        chk("rd_unal_resp", r, 2'h3);
        chk("rd_unal_data", d, 32'h0);
        $display("test refuse done");
        print_verdict();
    end
endmodule
`default_nettype wire
